/* hdl/wmor_regs.vh */
`ifndef WMOR_REGS_VH
`define WMOR_REGS_VH

// Register addresses
`define WMOR_MSR_RANGE 32'hc0000085
`define WMOR_MSR_FEATURE 32'hc0000080
`define WMOR_RANGE_RESET 64'h0000000000000000
`define WMOR_ORDER_RESET 2'h0

// Feature register order-control bits
`define WMOR_SPEC_DIS_BIT 2
`define WMOR_GLOB_DIS_BIT 3

// Per-range field layout, within each 32-bit half
`define WMOR_UC_BIT 0
`define WMOR_WC_BIT 1
`define WMOR_MASK_LSB 2
`define WMOR_MASK_MSB 16
`define WMOR_BASE_LSB 17
`define WMOR_BASE_MSB 31
`define WMOR_HALF_W 32

// Physical address top bits compared against a range
`define WMOR_ADDR_LSB 17
`define WMOR_ADDR_MSB 31

// Merge buffer geometry
`define WMOR_LINE_LSB 3
`define WMOR_LANE_BIT 2
`define WMOR_BUF_BYTES 8
`define WMOR_BUF_FULL 8'hff
`define WMOR_BUF_EMPTY 8'h00

`endif

/* hdl/wmor_range_match.v */
`include "wmor_regs.vh"

module wmor_range_match (
    // Range definition
    input wire [31:0] range_cfg,
    // Address under test
    input wire [31:0] addr,
    // Classification
    output wire hit_uncacheable,
    output wire hit_combine
);
    wire [14:0] mask;
    wire [14:0] base;
    wire in_range;

    assign mask = range_cfg[`WMOR_MASK_MSB:`WMOR_MASK_LSB];
    assign base = range_cfg[`WMOR_BASE_MSB:`WMOR_BASE_LSB];
    // Low 17 address bits never take part: ranges sit on 128 Kbyte steps
    assign in_range = ((mask & base) == (mask & addr[`WMOR_ADDR_MSB:`WMOR_ADDR_LSB]));
    // Uncached wins over combine; combine alone still means uncacheable
    assign hit_uncacheable = in_range & (range_cfg[`WMOR_UC_BIT] | range_cfg[`WMOR_WC_BIT]);
    assign hit_combine = in_range & range_cfg[`WMOR_WC_BIT] & ~range_cfg[`WMOR_UC_BIT];
endmodule // wmor_range_match

/* hdl/wmor_top.v */
// How it works
// - Eight-byte buffer merges combining-range writes.
// - Drained pin negated stalls modified/exclusive commits.
// - Global disable set ignores pin, no ordering.
// - Speculative disable: order all but combining ranges.
// - Both clear: buffer emptied, then wait pin.
// - Reset clears both order-disable bits.
// - One 64-bit register holds both ranges.
// - Range register resets to all zeros.
// - Base field holds top fifteen address bits.
// - Masked base equals masked address means hit.
// - Uncached wins; combine alone means combining.
// - Uncacheable range: no read or write allocation.
// - Combining range: no allocation, writes merge.
// - Range bits 0/1 and 32/33 hold types.
// - Each cleared low mask bit doubles size.
`include "wmor_regs.vh"

module wmor_top (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Model-specific register port
    input wire msr_req,
    input wire msr_we,
    input wire [31:0] msr_addr,
    input wire [63:0] msr_wdata,
    output reg [63:0] msr_rdata,
    output reg msr_ack,
    output reg msr_err,
    // Address lookup for reads and allocation
    input wire [31:0] lk_addr,
    output reg lk_uncacheable,
    output reg lk_combine,
    // Noncacheable write requests from the core
    input wire wr_valid,
    input wire [31:0] wr_addr,
    input wire [31:0] wr_data,
    input wire [3:0] wr_be,
    output wire wr_ready,
    // External write cycle
    output reg bus_wr_valid,
    output reg [31:0] bus_wr_addr,
    output reg [63:0] bus_wr_data,
    output reg [7:0] bus_wr_be,
    input wire bus_wr_ready,
    // Cache write commit gate
    input wire cache_commit_req,
    input wire cache_line_mod_excl,
    output wire cache_commit_ok,
    // System pin and order mode view
    input wire ext_writes_drained_n,
    output wire [1:0] write_order_control
);
    localparam ST_IDLE = 1'b0;
    localparam ST_BUS = 1'b1;

    reg [63:0] range_ctl_q;
    reg glob_dis_q;
    reg spec_dis_q;
    reg drain_s1_q, drain_s2_q, drain_s3_q;
    reg drained_q;
    reg state_q, state_d;
    reg [31:0] buf_addr_q, buf_addr_d;
    reg [63:0] buf_data_q, buf_data_d;
    reg [7:0] buf_be_q, buf_be_d;
    reg bus_wr_valid_d;
    reg [31:0] bus_wr_addr_d;
    reg [63:0] bus_wr_data_d;
    reg [7:0] bus_wr_be_d;
    integer i;

    wire [1:0] wr_uc, wr_wc, lk_uc, lk_wc;
    wire wr_is_wc;
    wire buf_any;
    wire same_line;
    wire full_order;
    wire need_flush;

    // Both ranges, checked for the write path and the lookup path
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_range
            wmor_range_match u_wr (
                .range_cfg(range_ctl_q[g*`WMOR_HALF_W +: `WMOR_HALF_W]),
                .addr(wr_addr),
                .hit_uncacheable(wr_uc[g]),
                .hit_combine(wr_wc[g])
            );
            wmor_range_match u_lk (
                .range_cfg(range_ctl_q[g*`WMOR_HALF_W +: `WMOR_HALF_W]),
                .addr(lk_addr),
                .hit_uncacheable(lk_uc[g]),
                .hit_combine(lk_wc[g])
            );
        end
    endgenerate

    // A plain uncacheable hit in either range keeps the write out of the buffer
    assign wr_is_wc = (|wr_wc) & ~(|(wr_uc & ~wr_wc));
    assign buf_any = (buf_be_q != `WMOR_BUF_EMPTY);
    assign same_line = (buf_addr_q[`WMOR_ADDR_MSB:`WMOR_LINE_LSB]
                        == wr_addr[`WMOR_ADDR_MSB:`WMOR_LINE_LSB]);
    assign full_order = ~glob_dis_q & ~spec_dis_q;
    assign write_order_control = {glob_dis_q, spec_dis_q};

    // Flush before accepting anything that cannot join the buffer
    assign need_flush = buf_any & ((buf_be_q == `WMOR_BUF_FULL)
                        | (wr_valid & ~(wr_is_wc & same_line))
                        | (full_order & cache_commit_req & cache_line_mod_excl));
    assign wr_ready = (state_q == ST_IDLE) & ~need_flush;

    // Unless global disable is set, commits to M/E lines wait for the pin; full order also waits for the buffer
    assign cache_commit_ok = cache_commit_req & (glob_dis_q
        | ~cache_line_mod_excl
        | (drained_q
           & ~(full_order & (buf_any | (state_q == ST_BUS)))));

    // Pin synchroniser; a change counts once stages two and three agree
    // Stages reset to the drained pin level, so no false stall follows reset
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            drain_s1_q <= 1'b0;
            drain_s2_q <= 1'b0;
            drain_s3_q <= 1'b0;
            drained_q <= 1'b1;
        end else begin
            drain_s1_q <= ext_writes_drained_n;
            drain_s2_q <= drain_s1_q;
            drain_s3_q <= drain_s2_q;
            if (drain_s2_q == drain_s3_q) begin
                drained_q <= ~drain_s3_q;
            end
        end
    end

    // Register port: one cycle answer, unmapped addresses flag an error
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            range_ctl_q <= `WMOR_RANGE_RESET;
            glob_dis_q <= 1'b0;
            spec_dis_q <= 1'b0;
            msr_rdata <= `WMOR_RANGE_RESET;
            msr_ack <= 1'b0;
            msr_err <= 1'b0;
        end else begin
            msr_ack <= msr_req;
            msr_err <= 1'b0;
            msr_rdata <= `WMOR_RANGE_RESET;
            if (msr_req) begin
                if (msr_addr == `WMOR_MSR_RANGE) begin
                    if (msr_we) begin
                        range_ctl_q <= msr_wdata;
                    end else begin
                        msr_rdata <= range_ctl_q;
                    end
                end else if (msr_addr == `WMOR_MSR_FEATURE) begin
                    if (msr_we) begin
                        glob_dis_q <= msr_wdata[`WMOR_GLOB_DIS_BIT];
                        spec_dis_q <= msr_wdata[`WMOR_SPEC_DIS_BIT];
                    end else begin
                        msr_rdata[`WMOR_GLOB_DIS_BIT] <= glob_dis_q;
                        msr_rdata[`WMOR_SPEC_DIS_BIT] <= spec_dis_q;
                    end
                end else begin
                    msr_err <= 1'b1;
                end
            end
        end
    end

    // Lookup answers: uncacheable means no line is allocated
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lk_uncacheable <= 1'b0;
            lk_combine <= 1'b0;
        end else begin
            lk_uncacheable <= |lk_uc;
            lk_combine <= (|lk_wc) & ~(|(lk_uc & ~lk_wc));
        end
    end

    // Merge buffer and external write sequencer
    always @* begin
        state_d = state_q;
        buf_addr_d = buf_addr_q;
        buf_data_d = buf_data_q;
        buf_be_d = buf_be_q;
        bus_wr_valid_d = bus_wr_valid;
        bus_wr_addr_d = bus_wr_addr;
        bus_wr_data_d = bus_wr_data;
        bus_wr_be_d = bus_wr_be;
        case (state_q)
            ST_IDLE: begin
                if (need_flush) begin
                    // Whole buffer goes out as one write cycle
                    bus_wr_valid_d = 1'b1;
                    bus_wr_addr_d = buf_addr_q;
                    bus_wr_data_d = buf_data_q;
                    bus_wr_be_d = buf_be_q;
                    buf_be_d = `WMOR_BUF_EMPTY;
                    state_d = ST_BUS;
                end else if (wr_valid) begin
                    if (wr_is_wc) begin
                        if (!buf_any) begin
                            buf_addr_d = {wr_addr[`WMOR_ADDR_MSB:`WMOR_LINE_LSB], 3'h0};
                        end
                        for (i = 0; i < 4; i = i + 1) begin
                            if (wr_be[i]) begin
                                if (wr_addr[`WMOR_LANE_BIT]) begin
                                    buf_data_d[(4+i)*8 +: 8] = wr_data[i*8 +: 8];
                                    buf_be_d[4+i] = 1'b1;
                                end else begin
                                    buf_data_d[i*8 +: 8] = wr_data[i*8 +: 8];
                                    buf_be_d[i] = 1'b1;
                                end
                            end
                        end
                    end else begin
                        // Uncacheable writes go straight out, never allocated
                        bus_wr_valid_d = 1'b1;
                        bus_wr_addr_d = {wr_addr[`WMOR_ADDR_MSB:`WMOR_LINE_LSB], 3'h0};
                        if (wr_addr[`WMOR_LANE_BIT]) begin
                            bus_wr_data_d = {wr_data, 32'h00000000};
                            bus_wr_be_d = {wr_be, 4'h0};
                        end else begin
                            bus_wr_data_d = {32'h00000000, wr_data};
                            bus_wr_be_d = {4'h0, wr_be};
                        end
                        state_d = ST_BUS;
                    end
                end
            end
            ST_BUS: begin
                if (bus_wr_ready) begin
                    bus_wr_valid_d = 1'b0;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            buf_addr_q <= 32'h00000000;
            buf_data_q <= 64'h0000000000000000;
            buf_be_q <= `WMOR_BUF_EMPTY;
            bus_wr_valid <= 1'b0;
            bus_wr_addr <= 32'h00000000;
            bus_wr_data <= 64'h0000000000000000;
            bus_wr_be <= 8'h00;
        end else begin
            state_q <= state_d;
            buf_addr_q <= buf_addr_d;
            buf_data_q <= buf_data_d;
            buf_be_q <= buf_be_d;
            bus_wr_valid <= bus_wr_valid_d;
            bus_wr_addr <= bus_wr_addr_d;
            bus_wr_data <= bus_wr_data_d;
            bus_wr_be <= bus_wr_be_d;
        end
    end
endmodule // wmor_top

/* test/wmor_asserts.sv */
`include "wmor_regs.vh"

module wmor_asserts (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Watched ports
    input wire msr_req,
    input wire [31:0] msr_addr,
    input wire msr_ack,
    input wire msr_err,
    input wire bus_wr_valid,
    input wire [31:0] bus_wr_addr,
    input wire bus_wr_ready,
    input wire cache_commit_req,
    input wire cache_line_mod_excl,
    input wire cache_commit_ok,
    input wire ext_writes_drained_n,
    input wire [1:0] write_order_control
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_ack_next: assert property (msr_req |=> msr_ack) else $error("ack missing");
    a_ack_cause: assert property (msr_ack |-> $past(msr_req)) else $error("stray ack");
    a_range_mapped: assert property (msr_req && msr_addr == `WMOR_MSR_RANGE |=> !msr_err)
        else $error("range flagged");
    a_global_pass: assert property (write_order_control[1] && cache_commit_req
        |-> cache_commit_ok) else $error("global blocked");
    a_commit_cause: assert property (cache_commit_ok |-> cache_commit_req)
        else $error("grant without req");
    // Five samples cover the four-edge pin synchroniser
    a_pin_stall: assert property (ext_writes_drained_n [*5] ##0 (cache_commit_req
        && cache_line_mod_excl && !write_order_control[1]) |-> !cache_commit_ok)
        else $error("commit not stalled");
    a_bus_hold: assert property (bus_wr_valid && !bus_wr_ready
        |=> bus_wr_valid && $stable(bus_wr_addr)) else $error("bus not held");
    a_bus_drop: assert property (bus_wr_valid && bus_wr_ready |=> !bus_wr_valid)
        else $error("bus not dropped");
endmodule // wmor_asserts

bind wmor_top wmor_asserts u_chk (.clk, .rstn, .msr_req, .msr_addr, .msr_ack, .msr_err,
    .bus_wr_valid, .bus_wr_addr, .bus_wr_ready, .cache_commit_req, .cache_line_mod_excl,
    .cache_commit_ok, .ext_writes_drained_n, .write_order_control);

/* test/wmor_sys_model.sv */
module wmor_sys_model (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Bus and bench controls
    input wire bus_wr_valid,
    input wire hold_neg,
    input wire slow,
    // Answers
    output reg bus_wr_ready,
    output reg ext_writes_drained_n
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [2:0] wait_q;

    // Pin negated while a write is on the bus, so no later cache write passes it
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_q <= 3'h0;
            bus_wr_ready <= 1'b0;
            ext_writes_drained_n <= 1'b0;
        end else begin
            wait_q <= (bus_wr_valid && !bus_wr_ready) ? wait_q + 3'h1 : 3'h0;
            bus_wr_ready <= bus_wr_valid && !bus_wr_ready && wait_q >= (slow ? 3'h3 : 3'h0);
            ext_writes_drained_n <= hold_neg || (bus_wr_valid && !bus_wr_ready);
        end
    end
endmodule // wmor_sys_model

/* test/tb.sv */
`include "wmor_regs.vh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = '0, rstn = '0, msr_req = '0, msr_we = '0, wr_valid = '0, hold_neg = '0;
    logic slow = '0, cache_commit_req = '0, cache_line_mod_excl = '0;
    logic [31:0] msr_addr = '0, lk_addr = '0, wr_addr = '0, wr_data = '0, bus_wr_addr;
    logic [63:0] msr_wdata = '0, msr_rdata, bus_wr_data;
    logic [3:0] wr_be = '0;
    logic [7:0] bus_wr_be;
    logic [1:0] write_order_control;
    logic msr_ack, msr_err, lk_uncacheable, lk_combine, wr_ready, bus_wr_valid, bus_wr_ready;
    logic cache_commit_ok, ext_writes_drained_n;
    int num_errors = 0;
    int num_checks = 0;

    wmor_top dut (.clk, .rstn, .msr_req, .msr_we, .msr_addr, .msr_wdata, .msr_rdata, .msr_ack,
        .msr_err, .lk_addr, .lk_uncacheable, .lk_combine, .wr_valid, .wr_addr, .wr_data,
        .wr_be, .wr_ready, .bus_wr_valid, .bus_wr_addr, .bus_wr_data, .bus_wr_be,
        .bus_wr_ready, .cache_commit_req, .cache_line_mod_excl, .cache_commit_ok,
        .ext_writes_drained_n, .write_order_control);
    wmor_sys_model sys (.clk, .rstn, .bus_wr_valid, .hold_neg, .slow, .bus_wr_ready,
        .ext_writes_drained_n);

    initial forever #10 clk = ~clk;

    task automatic close_out();
        if (num_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic msr(input logic we, input logic [31:0] a, input logic [63:0] d);
        @(posedge clk) #1;
        msr_req = 1'b1;
        msr_we = we;
        msr_addr = a;
        msr_wdata = d;
        @(posedge clk) #1;
        msr_req = 1'b0;
        chk("msr ack", 1'h1, msr_ack);
        chk("msr err", (a != `WMOR_MSR_RANGE) && (a != `WMOR_MSR_FEATURE), msr_err);
    endtask

    // Valid is left high so merges can run back to back
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
        int i;
        wr_valid = 1'b1;
        wr_addr = a;
        wr_data = d;
        wr_be = be;
        #1;
        for (i = 0; i < 50 && wr_ready !== 1'b1; i++) @(posedge clk) #1;
        if (i == 50) begin
            num_errors++;
            close_out();
        end
        @(posedge clk) #1;
    endtask

    task automatic wait_bus();
        int i;
        for (i = 0; i < 50 && bus_wr_valid !== 1'b1; i++) @(posedge clk) #1;
        if (i == 50) begin
            num_errors++;
            close_out();
        end
    endtask

    task automatic t_reset();
        chk("order", 2'h0, write_order_control);
        msr(1'b0, `WMOR_MSR_RANGE, '0);
        chk("range rst", 64'h0, msr_rdata);
        msr(1'b1, 32'hc0000086, '1);
        chk("unmapped", 1'h1, msr_err);
    endtask

    task automatic t_ranges();
        int i;
        logic [31:0] a [7] = '{32'h01000000, 32'h01fffffc, 32'h02000000, 32'h00fffffc,
            32'h40000000, 32'h407ffffc, 32'h40800000};
        logic [1:0] e [7] = '{2'h2, 2'h2, 2'h0, 2'h0, 2'h3, 2'h3, 2'h0};
        msr(1'b1, `WMOR_MSR_RANGE, 64'h4001ff02_0101fe03);
        msr(1'b0, `WMOR_MSR_RANGE, '0);
        chk("range rd", 64'h4001ff02_0101fe03, msr_rdata);
        for (i = 0; i < 7; i++) begin
            lk_addr = a[i];
            @(posedge clk) #1;
            chk("lookup", e[i], {lk_uncacheable, lk_combine});
        end
    endtask

    task automatic t_order();
        int i;
        logic [1:0] m [3] = '{2'h1, 2'h2, 2'h0};
        cache_commit_req = 1'b1;
        cache_line_mod_excl = 1'b1;
        for (i = 0; i < 3; i++) begin
            msr(1'b1, `WMOR_MSR_FEATURE, {m[i], 2'h0});
            chk("mode", m[i], write_order_control);
            msr(1'b0, `WMOR_MSR_FEATURE, '0);
            chk("mode rd", {m[i], 2'h0}, msr_rdata);
            hold_neg = 1'b1;
            repeat (5) @(posedge clk) #1;
            chk("stall", m[i][1], cache_commit_ok);
            hold_neg = 1'b0;
            repeat (5) @(posedge clk) #1;
            wr(32'h40000100, 32'h0badf00d, 4'hf);
            wr_valid = 1'b0;
            chk("buf order", m[i] != 2'h0, cache_commit_ok);
        end
        wait_bus();
        chk("flush be", 8'h0f, bus_wr_be);
        for (i = 0; i < 20 && cache_commit_ok !== 1'b1; i++) @(posedge clk) #1;
        chk("released", 1'h1, cache_commit_ok);
        cache_commit_req = 1'b0;
    endtask

    task automatic t_merge();
        wr(32'h40000000, 32'h11223344, 4'hf);
        wr(32'h40000004, 32'h55667788, 4'hf);
        wr_valid = 1'b0;
        chk("full stall", 1'h0, wr_ready);
        wait_bus();
        chk("merge addr", 32'h40000000, bus_wr_addr);
        chk("merge data", 64'h55667788_11223344, bus_wr_data);
        chk("merge be", 8'hff, bus_wr_be);
        slow = 1'b1;
        wr(32'h01000014, 32'ha5a5a5a5, 4'h3);
        wr_valid = 1'b0;
        wait_bus();
        chk("uc addr", 32'h01000010, bus_wr_addr);
        chk("uc be", 8'h30, bus_wr_be);
        chk("uc data", 16'ha5a5, bus_wr_data[47:32]);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        #1 rstn = 1'b1;
        t_reset();
        t_ranges();
        t_order();
        t_merge();
        repeat (10) @(posedge clk);
        close_out();
    end
endmodule // tb
